// ---- design/rwf_consts.vh ----
// Constants of the receive wake filter: register indices, field positions,
// reset values and pulse timing. Definitions only.
`ifndef RWF_CONSTS_VH
`define RWF_CONSTS_VH

// Register indices; byte address on the bus is four times the index
`define RWF_IDX_CFG         12'h134
`define RWF_IDX_FLAGS       12'h135
`define RWF_IDX_IRQ_STATUS  12'h136
`define RWF_IDX_IRQ_ENABLE  12'h137
`define RWF_IDX_IRQ_CLEAR   12'h138

// receive_filter_config fields
`define RWF_CFG_MAGIC_WAKE   0
`define RWF_CFG_PATTERN_WAKE 1
`define RWF_CFG_BCAST_WAKE   2
`define RWF_CFG_UCAST_WAKE   4
`define RWF_CFG_EXT_RX       7
`define RWF_CFG_STYLE        8
`define RWF_CFG_LEN_LO       9
`define RWF_CFG_LEN_HI       10
`define RWF_CFG_LEVEL_CLEAR  11
`define RWF_CFG_RESET        16'h1000
`define RWF_CFG_WR_MASK      16'hf7ff

// receive_filter_flags fields
`define RWF_FLG_MAGIC        0
`define RWF_FLG_PATTERN      1
`define RWF_FLG_BCAST        2
`define RWF_FLG_UCAST        4
`define RWF_FLG_BAD_CRC      6
`define RWF_FLG_FRAME_DELIMITER_ERROR_FLAG      7
`define RWF_FLG_RESET        8'h00
`define RWF_FLG_USED_MASK    8'hd7

// Wake output style and pulse timing
`define RWF_STYLE_PULSE      1'b0
`define RWF_STYLE_LEVEL      1'b1
`define RWF_PULSE_BASE_CYC   7'h08

`endif

// ---- design/rwf_flag_bank.v ----
// Bank of sticky flags: a set pulse raises a bit, a clear mask drops it.
// Assumes set and clear are single-cycle strobes in the clock domain.
`timescale 1ns/100ps
`include "rwf_consts.vh"

module rwf_flag_bank #(
    parameter WIDTH = 8
) (
    // Clock and reset
    input  wire             clock,
    input  wire             sys_rst,
    // Flag control
    input  wire [WIDTH-1:0] set_vec,
    input  wire [WIDTH-1:0] clr_vec,
    output reg  [WIDTH-1:0] flags_q
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1)
        begin : g_flag
            // A set in the same cycle as a clear wins, so no event is lost
            always @(posedge clock)
            begin
                if (sys_rst)
                    flags_q[i] <= 1'b0;
                else
                    flags_q[i] <= set_vec[i] | (flags_q[i] & ~clr_vec[i]);
            end
        end
    endgenerate

endmodule

// ---- design/rwf_wake_out.v ----
// Wake indication generator: pulse of programmable length or held level.
// Assumes trigger and level clear are single-cycle strobes.
`timescale 1ns/100ps
`include "rwf_consts.vh"

module rwf_wake_out (
    // Clock and reset
    input  wire       clock,
    input  wire       sys_rst,
    // Control
    input  wire       trigger,
    input  wire       style,
    input  wire [1:0] length_code,
    input  wire       level_clear,
    // Output
    output reg        wake_q
);

    reg  [6:0] remain_q;
    wire [6:0] pulse_len;

    assign pulse_len = `RWF_PULSE_BASE_CYC << length_code;

    always @(posedge clock)
    begin
        if (sys_rst)
        begin
            wake_q   <= 1'b0;
            remain_q <= 7'h00;
        end
        else if (trigger)
        begin
            // Retrigger restarts a running pulse; set beats a same-cycle clear
            wake_q   <= 1'b1;
            remain_q <= pulse_len - 7'h01;
        end
        else if (style == `RWF_STYLE_LEVEL)
        begin
            if (level_clear)
                wake_q <= 1'b0;
            remain_q <= 7'h00;
        end
        else if (remain_q != 7'h00)
            remain_q <= remain_q - 7'h01;
        else
            wake_q <= 1'b0;
    end

endmodule

// ---- design/rwf_top.v ----
// Receive wake filter: classifies received-frame events, keeps sticky
// clear-on-read flags, drives the wake indication pin and an interrupt.
// Assumes frame classification strobes come from the receive path in the
// same clock domain, and an Avalon-MM master with byte addressing.
// Notes on behaviour
// R1 - Style bit picks wake output form: 0 gives a pulse, 1 a held level.
// R2 - Pulse length code 0 to 3 selects 8, 16, 32 or 64 clock cycles.
// R3 - Level output stays high until software writes the clear bit; it reads 0.
// R4 - Extended receive enable switches on wake detection and CRC checking.
// R5 - Unicast wake enable raises a wake on every unicast frame received; the code never wakes on a frame with a bad CRC.
// R6 - Broadcast wake enable raises a wake on every broadcast frame received; the code never wakes on a frame with a bad CRC.
// R7 - Pattern wake enable raises a wake on a pattern-matching frame.
// R8 - Magic wake enable raises a wake on a received magic packet.
// R9 - Magic, pattern, broadcast, unicast flags in bits 0,1,2,4; clear on read.
// R10 - Bad CRC flag in bit 6, delimiter error flag in bit 7; clear on read.
// R11 - Wake output starts the cycle after an enabled wake condition is seen.
`timescale 1ns/100ps
`include "rwf_consts.vh"

module rwf_top #(
    parameter ADDR_WIDTH = 12
) (
    // Clock and reset
    input  wire                  clock,
    input  wire                  sys_rst,
    // Avalon-MM slave
    input  wire [ADDR_WIDTH-1:0] avs_address,
    input  wire                  avs_read,
    input  wire                  avs_write,
    input  wire [31:0]           avs_writedata,
    input  wire [3:0]            avs_byteenable,
    output reg  [31:0]           avs_readdata,
    output reg                   avs_waitrequest,
    // Receive path frame events
    input  wire                  rx_frame_end,
    input  wire                  rx_unicast,
    input  wire                  rx_broadcast,
    input  wire                  rx_pattern_match,
    input  wire                  rx_magic_packet,
    input  wire                  rx_crc_bad,
    input  wire                  rx_sfd_error,
    // Wake pin and interrupt
    output wire                  wake_indication,
    output reg                   irq
);

    // Register state
    reg  [15:0] receive_filter_config_q;
    reg  [15:0] receive_filter_config_d;
    reg  [7:0]  irq_enable_q;
    reg  [7:0]  irq_enable_d;
    reg  [31:0] readdata_d;
    wire [7:0]  receive_filter_flags;
    wire [7:0]  irq_status;

    // Bus decode
    wire        take;
    wire        rd_take;
    wire        wr_take;
    wire [15:0] lane_mask;
    wire        hit_cfg;
    wire        hit_flags;
    wire        hit_irq_status;
    wire        hit_irq_enable;
    wire        hit_irq_clear;

    // Frame classification
    wire        extended_rx_enable;
    wire        good_frame;
    reg  [7:0]  event_vec;
    wire        wake_hit;
    wire        wake_level_clear;
    wire [7:0]  flag_clear;
    wire [7:0]  irq_clear;

    // Address match against a register index; the bus carries byte addresses
    function addr_hits;
        input [ADDR_WIDTH-1:0] addr;
        input [11:0]           idx;
        begin
            addr_hits = (addr[1:0] == 2'b00) &&
                        (addr[ADDR_WIDTH-1:2] == idx[ADDR_WIDTH-3:0]);
        end
    endfunction

    assign hit_cfg        = addr_hits(avs_address, `RWF_IDX_CFG);
    assign hit_flags      = addr_hits(avs_address, `RWF_IDX_FLAGS);
    assign hit_irq_status = addr_hits(avs_address, `RWF_IDX_IRQ_STATUS);
    assign hit_irq_enable = addr_hits(avs_address, `RWF_IDX_IRQ_ENABLE);
    assign hit_irq_clear  = addr_hits(avs_address, `RWF_IDX_IRQ_CLEAR);

    // A request is taken while waitrequest is high; the answer follows one
    // cycle later with waitrequest low, so each access costs two cycles.
    assign take    = (avs_read | avs_write) & avs_waitrequest;
    assign rd_take = take & avs_read;
    assign wr_take = take & avs_write & ~avs_read;

    assign lane_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

    always @(posedge clock)
    begin
        if (sys_rst)
            avs_waitrequest <= 1'b1;
        else
            avs_waitrequest <= ~take;
    end

    // Configuration register; the level clear bit is a write pulse only
    always @*
    begin
        receive_filter_config_d = receive_filter_config_q;
        if (wr_take && hit_cfg)
            receive_filter_config_d = (receive_filter_config_q & ~(lane_mask & `RWF_CFG_WR_MASK))
                                    | (avs_writedata[15:0] & lane_mask & `RWF_CFG_WR_MASK);
    end

    always @(posedge clock)
    begin
        if (sys_rst)
            receive_filter_config_q <= `RWF_CFG_RESET;
        else
            receive_filter_config_q <= receive_filter_config_d;
    end

    assign wake_level_clear = wr_take & hit_cfg & avs_byteenable[1]
                            & avs_writedata[`RWF_CFG_LEVEL_CLEAR]; // R3

    // Interrupt enable register
    always @*
    begin
        irq_enable_d = irq_enable_q;
        if (wr_take && hit_irq_enable && avs_byteenable[0])
            irq_enable_d = avs_writedata[7:0] & `RWF_FLG_USED_MASK;
    end

    always @(posedge clock)
    begin
        if (sys_rst)
            irq_enable_q <= 8'h00;
        else
            irq_enable_q <= irq_enable_d;
    end

    // Frame events. Wake classes and CRC checking need the extended receive
    // path; a frame with a bad CRC never counts as a wake source.
    assign extended_rx_enable = receive_filter_config_q[`RWF_CFG_EXT_RX];
    assign good_frame = rx_frame_end & ~rx_crc_bad & extended_rx_enable; // R4

    always @*
    begin
        event_vec = 8'h00;
        event_vec[`RWF_FLG_MAGIC]   = good_frame & rx_magic_packet;       // R9
        event_vec[`RWF_FLG_PATTERN] = good_frame & rx_pattern_match;      // R9
        event_vec[`RWF_FLG_BCAST]   = good_frame & rx_broadcast;          // R9
        event_vec[`RWF_FLG_UCAST]   = good_frame & rx_unicast;            // R9
        event_vec[`RWF_FLG_BAD_CRC] = rx_frame_end & rx_crc_bad
                                    & extended_rx_enable;                 // R10
        event_vec[`RWF_FLG_FRAME_DELIMITER_ERROR_FLAG] = rx_sfd_error;                       // R10
    end

    assign wake_hit =
        (event_vec[`RWF_FLG_UCAST]   & receive_filter_config_q[`RWF_CFG_UCAST_WAKE])   // R5
      | (event_vec[`RWF_FLG_BCAST]   & receive_filter_config_q[`RWF_CFG_BCAST_WAKE])   // R6
      | (event_vec[`RWF_FLG_PATTERN] & receive_filter_config_q[`RWF_CFG_PATTERN_WAKE]) // R7
      | (event_vec[`RWF_FLG_MAGIC]   & receive_filter_config_q[`RWF_CFG_MAGIC_WAKE]);  // R8

    // Reading the flags clears them; an event in the same cycle survives
    assign flag_clear = (rd_take && hit_flags) ? 8'hff : 8'h00; // R9 R10

    rwf_flag_bank #(
        .WIDTH   (8)
    ) u_rx_flags (
        .clock   (clock),
        .sys_rst (sys_rst),
        .set_vec (event_vec),
        .clr_vec (flag_clear),
        .flags_q (receive_filter_flags)
    );

    // Interrupt status mirrors the events; cleared by writing ones
    assign irq_clear = (wr_take && hit_irq_clear && avs_byteenable[0]) ?
                       avs_writedata[7:0] : 8'h00;

    rwf_flag_bank #(
        .WIDTH   (8)
    ) u_irq_status (
        .clock   (clock),
        .sys_rst (sys_rst),
        .set_vec (event_vec),
        .clr_vec (irq_clear),
        .flags_q (irq_status)
    );

    always @(posedge clock)
    begin
        if (sys_rst)
            irq <= 1'b0;
        else
            irq <= |(irq_status & irq_enable_q);
    end

    // Wake pin: registered one cycle after the enabled condition
    rwf_wake_out u_wake_out (
        .clock       (clock),
        .sys_rst     (sys_rst),
        .trigger     (wake_hit),                                          // R11
        .style       (receive_filter_config_q[`RWF_CFG_STYLE]),           // R1
        .length_code (receive_filter_config_q[`RWF_CFG_LEN_HI:`RWF_CFG_LEN_LO]), // R2
        .level_clear (wake_level_clear),                                  // R3
        .wake_q      (wake_indication)
    );

    // Read data is captured at the take edge, before any read clear acts.
    // Unmapped and write-only addresses read as zero.
    always @*
    begin
        readdata_d = 32'h0000_0000;
        if (hit_cfg)
            readdata_d[15:0] = receive_filter_config_q;
        else if (hit_flags)
            readdata_d[7:0] = receive_filter_flags;
        else if (hit_irq_status)
            readdata_d[7:0] = irq_status;
        else if (hit_irq_enable)
            readdata_d[7:0] = irq_enable_q;
    end

    always @(posedge clock)
    begin
        if (sys_rst)
            avs_readdata <= 32'h0000_0000;
        else if (rd_take)
            avs_readdata <= readdata_d;
    end

endmodule

// ---- test/rwf_checker.sv ----
// Port checker of the receive wake filter: bus answer, wake pin timing.
// Assumes byte addressing: config at 0x4d0, flags at 0x4d4.
`timescale 1ns/100ps
module rwf_checker #(
    parameter ADDR_WIDTH = 12
) (
    // Clock and reset
    input wire                  clock,
    input wire                  sys_rst,
    // Register bus
    input wire [ADDR_WIDTH-1:0] avs_address,
    input wire                  avs_read,
    input wire                  avs_write,
    input wire [31:0]           avs_writedata,
    input wire [3:0]            avs_byteenable,
    input wire [31:0]           avs_readdata,
    input wire                  avs_waitrequest,
    // Frame events and pin
    input wire                  rx_frame_end,
    input wire                  rx_unicast,
    input wire                  rx_broadcast,
    input wire                  rx_pattern_match,
    input wire                  rx_magic_packet,
    input wire                  rx_crc_bad,
    input wire                  wake_indication
);
    reg  [15:0] c_q;
    reg  [7:0]  since_q;
    wire take = avs_waitrequest && avs_write && avs_address == 12'h4d0;
    wire clr  = take && avs_byteenable[1] && avs_writedata[11];
    wire [7:0] len = 8'h08 << c_q[10:9];
    wire hit = rx_frame_end && !rx_crc_bad && c_q[7] && |({rx_unicast, rx_broadcast,
        rx_pattern_match, rx_magic_packet} & {c_q[4], c_q[2:0]});
    // Saturates so a long idle spell never looks like a fresh pulse
    always @(posedge clock)
    begin
        if (sys_rst)
        begin
            c_q <= 16'h1000;
            since_q <= 8'hff;
        end
        else
        begin
            if (take && avs_byteenable[0]) c_q[7:0] <= avs_writedata[7:0];
            if (take && avs_byteenable[1]) c_q[15:8] <= avs_writedata[15:8];
            since_q <= hit ? 8'h01 : since_q + {7'h0, since_q != 8'hff};
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    property p_hit;
        hit |=> wake_indication;
    endproperty
    a_hit: assert property (p_hit) else $error("wake missed");
    property p_rise;
        $rose(wake_indication) |-> $past(hit);
    endproperty
    a_rise: assert property (p_rise) else $error("wake without cause");
    property p_pulse;
        !c_q[8] |-> wake_indication == (since_q <= len);
    endproperty
    a_pulse: assert property (p_pulse) else $error("pulse length wrong");
    property p_hold;
        c_q[8] && wake_indication && !clr |=> wake_indication;
    endproperty
    a_hold: assert property (p_hold) else $error("level dropped");
    property p_clr;
        c_q[8] && clr && !hit |=> !wake_indication;
    endproperty
    a_clr: assert property (p_clr) else $error("level not cleared");
    property p_cfgrd;
        !avs_waitrequest && avs_read && avs_address == 12'h4d0
            |-> avs_readdata == {16'h0, c_q & 16'hf7ff};
    endproperty
    a_cfgrd: assert property (p_cfgrd) else $error("config read wrong");
    property p_flgrd;
        !avs_waitrequest && avs_read && avs_address == 12'h4d4
            |-> (avs_readdata & 32'hffffff28) == 32'h0;
    endproperty
    a_flgrd: assert property (p_flgrd) else $error("reserved flag set");
    property p_ans;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_ans: assert property (p_ans) else $error("bus answer late");
endmodule
bind rwf_top rwf_checker #(.ADDR_WIDTH(ADDR_WIDTH)) u_chk (.clock(clock), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .rx_frame_end(rx_frame_end), .rx_unicast(rx_unicast), .rx_broadcast(rx_broadcast),
    .rx_pattern_match(rx_pattern_match), .rx_magic_packet(rx_magic_packet),
    .rx_crc_bad(rx_crc_bad), .wake_indication(wake_indication));

// ---- test/rwf_host_mon.sv ----
// Host watching the wake pin: counts high runs and their length.
// Assumes the pin is sampled on the block's own clock.
`timescale 1ns/100ps
module rwf_host_mon (
    // Clock and pin
    input  wire clock,
    input  wire wake_indication,
    // Measurement
    output int  runs,
    output int  run_len
);
    int cur = 0;
    initial runs = 0;
    always @(posedge clock)
    begin
        if (wake_indication === 1'b1)
            cur <= cur + 1;
        else if (cur != 0)
        begin
            runs <= runs + 1;
            run_len <= cur;
            cur <= 0;
        end
    end
endmodule

// ---- test/rwf_top_bench.sv ----
// Bench of the receive wake filter: bus and frame stimulus, integer model.
// Assumes the design answers each bus request one cycle after taking it.
`timescale 1ns/100ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fail_count++; \
    $display("unexpected at %0t: %h %h", $time, a, b); end end
module rwf_top_bench;
    reg         clock = 0, sys_rst = 1, rd = 0, wr = 0, fe = 0, sfd = 0;
    reg  [11:0] adr = 0;
    reg  [31:0] wd = 0, q, mf;
    reg  [3:0]  be = 4'hf;
    reg  [4:0]  rx = 0, r;
    reg  [15:0] c;
    wire [31:0] rdat;
    wire        wreq, wake, irq;
    int         fail_count = 0, num_checks = 0, runs, len, n, k, e;
    rwf_top uut (.clock(clock), .sys_rst(sys_rst), .avs_address(adr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat),
        .avs_waitrequest(wreq), .rx_frame_end(fe), .rx_unicast(rx[3]),
        .rx_broadcast(rx[2]), .rx_pattern_match(rx[1]), .rx_magic_packet(rx[0]),
        .rx_crc_bad(rx[4]), .rx_sfd_error(sfd), .wake_indication(wake), .irq(irq));
    rwf_host_mon mon (.clock(clock), .wake_indication(wake), .runs(runs), .run_len(len));
    initial
    begin
        forever #4 clock = ~clock;
    end
    task bus(input w, input [11:0] a, input [31:0] d);
        begin
            adr <= a; wd <= d; rd <= !w; wr <= w;
            @(posedge clock);
            while (wreq !== 1'b0) @(posedge clock);
            q = rdat;
            rd <= 0; wr <= 0;
            @(posedge clock);
        end
    endtask
    // Long idle tail lets a 64-cycle pulse finish before the next step
    task frame(input [4:0] f);
        begin
            rx <= f; fe <= 1;
            @(posedge clock);
            fe <= 0;
            repeat (70) @(posedge clock);
        end
    endtask
    task complete_run;
        begin
            $display("checks %0d mismatches %0d", num_checks, fail_count);
            if (fail_count == 0 && num_checks > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    // Whole run is near 2400 cycles; five times that means a hang
    initial
    begin
        #100000;
        fail_count++;
        complete_run;
    end
    initial
    begin
        k = $urandom(32'h0fd14974);
        repeat (16) @(posedge clock);
        sys_rst <= 0;
        @(posedge clock);
        bus(0, 12'h4d0, 0); `CHK(q, 32'h1000)
        bus(0, 12'h4d4, 0); `CHK(q, 32'h0)
        bus(0, 12'h100, 0); `CHK(q, 32'h0)
        $display("reset test done");
        for (k = 0; k < 4; k++)
        begin
            n = runs;
            bus(1, 12'h4d0, 32'h1090 | k << 9);
            frame(5'h08);
            `CHK(runs, n + 1)
            `CHK(len, 8 << k)
        end
        bus(0, 12'h4d4, 0); `CHK(q, 32'h10)
        $display("pulse test done");
        for (k = 0; k < 24; k++)
        begin
            c = {8'h0, 8'($urandom) & 8'h97};
            r = 5'($urandom) & 5'h0f;
            e = c[7] && |(r[3:0] & {c[4], c[2:0]});
            mf = c[7] ? {r[3], 1'b0, r[2:0]} : 0;
            n = runs;
            bus(1, 12'h4d0, c);
            frame(r);
            `CHK(runs, n + e)
            bus(0, 12'h4d4, 0); `CHK(q, mf)
        end
        $display("source test done");
        bus(1, 12'h4d0, 32'h0190);
        frame(5'h08);
        `CHK(wake, 1'b1)
        bus(1, 12'h4d0, 32'h0990);
        `CHK(wake, 1'b0)
        bus(0, 12'h4d0, 0); `CHK(q, 32'h0190)
        be <= 4'h2;
        bus(1, 12'h4d0, 32'hffff);
        be <= 4'hf;
        bus(0, 12'h4d0, 0); `CHK(q, 32'hf790)
        // The level-mode unicast frame must leave only its own flag behind
        bus(0, 12'h4d4, 0); `CHK(q, 32'h10)
        $display("level test done");
        bus(1, 12'h4d0, 32'h0);
        bus(1, 12'h4dc, 32'h80);
        sfd <= 1;
        @(posedge clock);
        sfd <= 0;
        repeat (3) @(posedge clock);
        `CHK(irq, 1'b1)
        bus(0, 12'h4dc, 0); `CHK(q, 32'h80)
        bus(0, 12'h4d8, 0); `CHK(q & 32'h80, 32'h80)
        bus(0, 12'h4d4, 0); `CHK(q, 32'h80)
        bus(1, 12'h4e0, 32'h80);
        `CHK(irq, 1'b0)
        bus(1, 12'h4dc, 32'h0);
        bus(1, 12'h4d0, 32'h0090);
        n = runs;
        frame(5'h18);
        `CHK(runs, n)
        `CHK(irq, 1'b0)
        bus(0, 12'h4d4, 0); `CHK(q & 32'h40, 32'h40)
        $display("error test done");
        complete_run;
    end
endmodule
